// *** common/dac_fault_pkg.sv ***
package dac_fault_pkg;
    // Channel and word geometry
    localparam int NUM_CH = 5;
    localparam int CODE_W = 16;
    localparam int SPAN_W = 4;
    localparam int CMD_W = 4;
    localparam int WORD_W = 24;
    localparam int ECHO_W = 32;
    localparam int FLAG_W = 8;
    localparam int CFG_W = 4;
    localparam logic [4:0] BITS_SHORT = 5'h18;
    localparam logic [4:0] BITS_LAST = 5'h1F;

    // Command codes
    localparam logic [CMD_W-1:0] CMD_WR_N = 4'h0;
    localparam logic [CMD_W-1:0] CMD_UPD_N = 4'h1;
    localparam logic [CMD_W-1:0] CMD_WR_N_UPD_ALL = 4'h2;
    localparam logic [CMD_W-1:0] CMD_WR_N_UPD_N = 4'h3;
    localparam logic [CMD_W-1:0] CMD_PD_N = 4'h4;
    localparam logic [CMD_W-1:0] CMD_PD_CHIP = 4'h5;
    localparam logic [CMD_W-1:0] CMD_SPAN_N = 4'h6;
    localparam logic [CMD_W-1:0] CMD_CONFIG = 4'h7;
    localparam logic [CMD_W-1:0] CMD_WR_ALL = 4'h8;
    localparam logic [CMD_W-1:0] CMD_UPD_ALL = 4'h9;
    localparam logic [CMD_W-1:0] CMD_WR_ALL_UPD_ALL = 4'hA;
    localparam logic [CMD_W-1:0] CMD_SPAN_ALL = 4'hB;

    // Configuration bit positions
    localparam int CFG_RD = 0;
    localparam int CFG_TS = 1;
    localparam int CFG_PL = 2;
    localparam int CFG_OC = 3;

    // Span codes
    localparam logic [SPAN_W-1:0] SPAN_HIZ = 4'h0;
    localparam logic [SPAN_W-1:0] SPAN_100MA = 4'h3;
    localparam logic [SPAN_W-1:0] SPAN_200MA = 4'h4;
    localparam logic [SPAN_W-1:0] SPAN_300MA = 4'h5;
    localparam logic [SPAN_W-1:0] SPAN_NEG = 4'h8;

    // Flag positions in the status byte
    localparam int FLAG_OVT = 5;
    localparam int FLAG_PWR = 6;
    localparam int FLAG_LEN = 7;

    // APB register offsets and status fields
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CONFIG = 8'h04;
    localparam logic [7:0] REG_POWER = 8'h08;
    localparam logic [7:0] REG_SPAN = 8'h0C;
    localparam int ST_SHUTDOWN = 8;
    localparam int ST_ALARM = 9;
    localparam int ST_PIN = 10;
    localparam int PW_REF = 5;
    localparam int PW_WAKE = 6;

    // Pin input indices in the synchroniser bank
    localparam int IN_SEL = 0;
    localparam int IN_SCK = 1;
    localparam int IN_SDI = 2;
    localparam int IN_OPEN = 3;
    localparam int IN_PWR = 8;
    localparam int IN_OVT = 13;
    localparam int IN_COOL = 14;
    localparam int IN_PIN = 15;
    localparam int IN_W = 16;
    localparam logic [IN_W-1:0] IN_IDLE = 16'h8001;

    // Wake-up settling times
    localparam int CLK_PERIOD_PS = 25000;
    localparam int WAKE_CH_US = 30;
    localparam int WAKE_CHIP_US = 35;
    localparam int WAKE_W = 11;
    localparam int WAKE_CH_CYC = (WAKE_CH_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WAKE_CHIP_CYC = (WAKE_CHIP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage : dac_fault_pkg

// *** logic/dac_fault_config_powerdown.sv ***
`timescale 1ns/1ps
module dac_fault_config_powerdown #(
    parameter int ADDR_W = 8
) (
    input  wire logic                                              core_clk_in,
    input  wire logic                                              reset_n_in,
    input  wire logic                                              clk_en_in,
    input  wire logic                                              psel_in,
    input  wire logic                                              penable_in,
    input  wire logic                                              pwrite_in,
    input  wire logic [ADDR_W-1:0]                                 paddr_in,
    input  wire logic [31:0]                                       pwdata_in,
    output logic      [31:0]                                       prdata_out,
    output logic                                                   pready_out,
    output logic                                                   pslverr_out,
    input  wire logic                                              select_load_n_in,
    input  wire logic                                              sck_in,
    input  wire logic                                              sdi_in,
    output logic                                                   sdo_out,
    output logic                                                   sdo_oe_n_out,
    input  wire logic [dac_fault_pkg::NUM_CH-1:0]                  open_detect_in,
    input  wire logic [dac_fault_pkg::NUM_CH-1:0]                  power_over_in,
    input  wire logic                                              overtemp_in,
    input  wire logic                                              temp_recovered_in,
    input  wire logic                                              alarm_pin_in,
    output logic                                                   alarm_pin_out,
    output logic                                                   alarm_oe_n_out,
    output logic [dac_fault_pkg::NUM_CH*dac_fault_pkg::CODE_W-1:0] dac_code_out,
    output logic [dac_fault_pkg::NUM_CH*dac_fault_pkg::SPAN_W-1:0] span_out,
    output logic [dac_fault_pkg::NUM_CH-1:0]                       output_hiz_out,
    output logic [dac_fault_pkg::NUM_CH-1:0]                       neg_switch_out,
    output logic                                                   ref_powered_down_out,
    output logic                                                   ext_ref_select_out
);
    import dac_fault_pkg::*;

    logic [IN_W-1:0]   raw_in;
    logic [IN_W-1:0]   stab;
    logic [IN_W-1:0]   chg;
    logic [4:0]        bit_cnt_q;
    logic              seen32_q;
    logic [WORD_W-1:0] shift_q;
    logic [WORD_W-1:0] echo_q;
    logic [ECHO_W-1:0] sdo_sr_q;
    logic [FLAG_W-1:0] alarm_status_byte;
    logic [FLAG_W-1:0] fault_live;
    logic [FLAG_W-1:0] fault_prev_q;
    logic [CFG_W-1:0]  cfg_q;
    logic              shutdown_q;
    logic              alarm_q;
    logic              chip_pd_q;
    logic [WAKE_W-1:0] wake_cnt_q;
    logic [NUM_CH-1:0] pd_q;
    logic [NUM_CH-1:0] span_hi;
    logic [NUM_CH-1:0] pl_fold;
    logic [NUM_CH-1:0] upd_ch;
    logic [NUM_CH*SPAN_W-1:0] span_flat;
    logic              sel_rise;
    logic              sel_fall;
    logic              sck_rise;
    logic              sck_fall;
    logic              active;
    logic              len_ok;
    logic              len_bad;
    logic              exec;
    logic              alarm_set;
    logic              ovt_live;
    logic              wake_any;
    logic              apb_wr;
    logic              rd_valid_q;
    logic [CMD_W-1:0]  cmd;
    logic [3:0]        addr;
    logic [CODE_W-1:0] data;

    // Pin and detector levels into one synchroniser bank
    assign raw_in = {alarm_pin_in, temp_recovered_in, overtemp_in, power_over_in,
                     open_detect_in, sdi_in, sck_in, select_load_n_in};

    // Three-stage synchroniser; a change counts once stages two and three agree
    generate
        for (genvar i = 0; i < IN_W; i++)
        begin : g_sync
            logic meta_q;
            logic s2_q;
            logic s3_q;
            logic st_q;
            always_ff @(posedge core_clk_in or negedge reset_n_in)
            begin
                if (!reset_n_in)
                begin
                    meta_q <= IN_IDLE[i];
                    s2_q   <= IN_IDLE[i];
                    s3_q   <= IN_IDLE[i];
                    st_q   <= IN_IDLE[i];
                end
                else if (clk_en_in)
                begin
                    meta_q <= raw_in[i];
                    s2_q   <= meta_q;
                    s3_q   <= s2_q;
                    if (s2_q == s3_q)
                        st_q <= s3_q;
                end
            end
            assign stab[i] = st_q;
            assign chg[i]  = (s2_q == s3_q) && (s3_q != st_q);
        end
    endgenerate

    // Edge events of the serial pins
    assign sel_rise = chg[IN_SEL] && stab[IN_SEL] == 1'b0;
    assign sel_fall = chg[IN_SEL] && stab[IN_SEL] == 1'b1;
    assign sck_rise = chg[IN_SCK] && stab[IN_SCK] == 1'b0 && active;
    assign sck_fall = chg[IN_SCK] && stab[IN_SCK] == 1'b1 && active;
    assign active   = !stab[IN_SEL];

    // Length check: 24, or a whole multiple of 32
    assign len_ok  = seen32_q ? (bit_cnt_q == '0) : (bit_cnt_q == BITS_SHORT);
    assign len_bad = !len_ok && (seen32_q || bit_cnt_q != '0);
    assign exec    = sel_rise && len_ok;
    assign cmd     = shift_q[WORD_W-1 -: CMD_W];
    assign addr    = shift_q[CODE_W +: 4];
    assign data    = shift_q[CODE_W-1:0];

    // Bit counter and input shift register
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            bit_cnt_q <= '0;
            seen32_q  <= 1'b0;
            shift_q   <= '0;
        end
        else if (clk_en_in)
        begin
            if (sel_fall)
            begin
                bit_cnt_q <= '0;
                seen32_q  <= 1'b0;
            end
            else if (sck_rise)
            begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
                shift_q   <= {shift_q[WORD_W-2:0], stab[IN_SDI]};
                if (bit_cnt_q == BITS_LAST)
                    seen32_q <= 1'b1;
            end
        end
    end

    // Echo readback: status byte then the previous instruction
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            echo_q   <= '0;
            sdo_sr_q <= '0;
        end
        else if (clk_en_in)
        begin
            if (sel_rise)
                echo_q <= shift_q;
            if (sel_fall)
                sdo_sr_q <= {alarm_status_byte, echo_q};
            else if (sck_fall)
                sdo_sr_q <= {sdo_sr_q[ECHO_W-2:0], 1'b0};
        end
    end
    assign sdo_out      = sdo_sr_q[ECHO_W-1];
    assign sdo_oe_n_out = !active;

    // Live fault conditions after the disable bits
    assign ovt_live = stab[IN_OVT] && !cfg_q[CFG_TS];
    generate
        for (genvar c = 0; c < NUM_CH; c++)
        begin : g_live
            assign span_hi[c] = span_flat[c*SPAN_W +: SPAN_W] == SPAN_200MA
                             || span_flat[c*SPAN_W +: SPAN_W] == SPAN_300MA;
            assign pl_fold[c] = stab[IN_PWR+c] && span_hi[c] && !cfg_q[CFG_PL];
        end
    endgenerate
    assign fault_live = {len_bad && sel_rise, |pl_fold, shutdown_q || ovt_live,
                         stab[IN_OPEN +: NUM_CH] & {NUM_CH{!cfg_q[CFG_OC]}}};

    // Thermal shutdown holds until the recovery level is reached or the TS disable bit is set
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            shutdown_q <= 1'b0;
        else if (clk_en_in)
        begin
            if (ovt_live)
                shutdown_q <= 1'b1;
            else if (stab[IN_COOL] || cfg_q[CFG_TS])
                shutdown_q <= 1'b0;
        end
    end

    // Sticky status byte, re-armed from live levels each transaction
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            alarm_status_byte <= '0;
        else if (clk_en_in)
        begin
            if (sel_fall)
                alarm_status_byte <= fault_live;
            else
                alarm_status_byte <= alarm_status_byte | fault_live;
        end
    end

    // Alarm pulls on any newly detected fault; select/load rise releases it
    assign alarm_set = |(fault_live & ~fault_prev_q);
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            fault_prev_q <= '0;
            alarm_q      <= 1'b0;
        end
        else if (clk_en_in)
        begin
            fault_prev_q <= fault_live;
            if (alarm_set)
                alarm_q <= 1'b1;
            else if (sel_rise)
                alarm_q <= 1'b0;
        end
    end
    assign alarm_pin_out  = 1'b0;
    assign alarm_oe_n_out = !alarm_q;

    // Configuration bits from the serial command or from APB
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            cfg_q <= '0;
        else if (clk_en_in)
        begin
            if (exec && cmd == CMD_CONFIG)
                cfg_q <= data[CFG_W-1:0];
            else if (apb_wr && paddr_in == REG_CONFIG)
                cfg_q <= pwdata_in[CFG_W-1:0];
        end
    end
    assign ext_ref_select_out = cfg_q[CFG_RD];

    // Per-channel code, span and power-down state
    generate
        for (genvar c = 0; c < NUM_CH; c++)
        begin : g_ch
            logic [CODE_W-1:0] in_code_q;
            logic [CODE_W-1:0] dac_code_q;
            logic [SPAN_W-1:0] span_q;
            logic              hit;
            logic              wr;
            logic              sp;
            assign hit = addr == 4'(c);
            assign wr  = exec && (((cmd == CMD_WR_N || cmd == CMD_WR_N_UPD_N
                         || cmd == CMD_WR_N_UPD_ALL) && hit)
                         || cmd == CMD_WR_ALL || cmd == CMD_WR_ALL_UPD_ALL);
            assign upd_ch[c] = exec && (((cmd == CMD_UPD_N || cmd == CMD_WR_N_UPD_N) && hit)
                         || cmd == CMD_UPD_ALL || cmd == CMD_WR_N_UPD_ALL
                         || cmd == CMD_WR_ALL_UPD_ALL);
            assign sp  = exec && ((cmd == CMD_SPAN_N && hit) || cmd == CMD_SPAN_ALL);
            always_ff @(posedge core_clk_in or negedge reset_n_in)
            begin
                if (!reset_n_in)
                begin
                    in_code_q  <= '0;
                    dac_code_q <= '0;
                    span_q     <= SPAN_HIZ;
                    pd_q[c]    <= 1'b0;
                end
                else if (clk_en_in)
                begin
                    if (wr)
                        in_code_q <= data;
                    if (upd_ch[c])
                        dac_code_q <= wr ? data : in_code_q;
                    if (pl_fold[c])
                        span_q <= SPAN_100MA;
                    else if (sp)
                        span_q <= data[SPAN_W-1:0];
                    if (upd_ch[c])
                        pd_q[c] <= 1'b0;
                    else if (exec && (cmd == CMD_PD_CHIP || (cmd == CMD_PD_N && hit)))
                        pd_q[c] <= 1'b1;
                end
            end
            assign dac_code_out[c*CODE_W +: CODE_W] = dac_code_q;
            assign span_flat[c*SPAN_W +: SPAN_W]    = span_q;
            assign neg_switch_out[c] = span_q == SPAN_NEG;
            assign output_hiz_out[c] = pd_q[c] || shutdown_q || span_q == SPAN_HIZ
                                    || span_q == SPAN_NEG;
        end
    endgenerate
    assign span_out = span_flat;

    // Reference power-down and wake-up settling counter
    assign wake_any = |(upd_ch & pd_q);
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            chip_pd_q  <= 1'b0;
            wake_cnt_q <= '0;
        end
        else if (clk_en_in)
        begin
            if (|upd_ch)
                chip_pd_q <= 1'b0;
            else if (exec && cmd == CMD_PD_CHIP)
                chip_pd_q <= 1'b1;
            if (wake_any)
                wake_cnt_q <= chip_pd_q ? WAKE_W'(WAKE_CHIP_CYC) : WAKE_W'(WAKE_CH_CYC);
            else if (wake_cnt_q != '0)
                wake_cnt_q <= wake_cnt_q - 11'h001;
        end
    end
    assign ref_powered_down_out = chip_pd_q;

    // APB slave: read data captured in setup, zero-wait answer
    assign pready_out = clk_en_in && penable_in && rd_valid_q;
    assign apb_wr     = psel_in && penable_in && pready_out && pwrite_in;
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            prdata_out  <= '0;
            pslverr_out <= 1'b0;
            rd_valid_q  <= 1'b0;
        end
        else if (clk_en_in)
        begin
            rd_valid_q  <= psel_in && !(penable_in && pready_out);
            pslverr_out <= 1'b0;
            case (paddr_in)
                REG_STATUS: prdata_out <= {21'h000000, stab[IN_PIN], alarm_q,
                                           shutdown_q, alarm_status_byte};
                REG_CONFIG: prdata_out <= {28'h0000000, cfg_q};
                REG_POWER:  prdata_out <= {25'h0000000, wake_cnt_q != '0, chip_pd_q, pd_q};
                REG_SPAN:   prdata_out <= {12'h000, span_flat};
                default:
                begin
                    prdata_out  <= '0;
                    pslverr_out <= 1'b1;
                end
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    a_bad_length: assert property (clk_en_in && sel_rise && len_bad |=>
        alarm_status_byte[FLAG_LEN] && alarm_q && $stable(cfg_q))
        else $error("bad length not flagged");
    a_alarm_release: assert property (clk_en_in && sel_rise && !alarm_set |=> !alarm_q)
        else $error("alarm not released");
    a_ovt_shutdown: assert property (clk_en_in && ovt_live |=>
        shutdown_q && (&output_hiz_out) && alarm_status_byte[FLAG_OVT])
        else $error("overtemperature not handled");
    a_ovt_hold: assert property (shutdown_q && !stab[IN_COOL] && !cfg_q[CFG_TS] |=>
        shutdown_q)
        else $error("shutdown left early");
    a_open_disable: assert property (clk_en_in && sel_fall && cfg_q[CFG_OC] |=>
        alarm_status_byte[NUM_CH-1:0] == '0)
        else $error("open flag while disabled");
    a_chip_pd: assert property (clk_en_in && exec && cmd == CMD_PD_CHIP |=>
        (&pd_q) && ref_powered_down_out)
        else $error("chip power-down failed");
    a_chan_pd: assert property (clk_en_in && exec && cmd == CMD_PD_N && addr == 4'h2 |=>
        pd_q[2] && output_hiz_out[2] && $stable(dac_code_out))
        else $error("channel power-down failed");
    a_wake_update: assert property (clk_en_in && exec && cmd == CMD_UPD_ALL |=>
        pd_q == '0 && wake_cnt_q != '0 || $past(pd_q) == '0)
        else $error("update did not wake");
    a_span_fold: assert property (clk_en_in && pl_fold[0] |=>
        span_flat[SPAN_W-1:0] == SPAN_100MA ##1 !pl_fold[0])
        else $error("span not reduced");
    a_flag_shift: assert property (clk_en_in && sel_fall |=>
        sdo_sr_q[ECHO_W-1 -: FLAG_W] == $past(alarm_status_byte))
        else $error("status byte not loaded");
    a_ref_reset: assert property ($rose(reset_n_in) |-> !ext_ref_select_out)
        else $error("reference bit not cleared");

    c_valid_cmd: cover property (exec && bit_cnt_q == '0 && seen32_q);
    c_short_cmd: cover property (exec && !seen32_q);
    c_bad_len:   cover property (sel_rise && len_bad);
    c_shutdown:  cover property ($rose(shutdown_q));
    c_fold:      cover property (pl_fold != '0);
endmodule : dac_fault_config_powerdown

// *** tb/spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic        core_clk_in,
    input  wire logic        sdo_in,
    output logic             sck_out,
    output logic             sdi_out,
    output logic             select_load_n_out,
    output logic      [31:0] echo_out
);
    // Parked idle: clock low, nothing selected
    initial
    begin
        sck_out = 1'b0;
        sdi_out = 1'b1;
        select_load_n_out = 1'b1;
        echo_out = '0;
    end
    // One frame of n bits, MSB first, 200 ns clock
    task automatic send(input logic [31:0] bits, input int n);
        @(posedge core_clk_in);
        select_load_n_out <= 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            sck_out <= 1'b0;
            sdi_out <= bits[i];
            repeat (4) @(posedge core_clk_in);
            sck_out <= 1'b1;
            repeat (4) @(posedge core_clk_in);
            echo_out <= {echo_out[30:0], sdo_in}; // Echo bit settled before clock falls
        end
        sck_out <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        select_load_n_out <= 1'b1;
        sdi_out <= ~sdi_out; // Released line never keeps its last bit
        repeat (8) @(posedge core_clk_in);
    endtask : send
endmodule : spi_host_model

// *** tb/tb_dac_fault_config_powerdown.sv ***
`timescale 1ns/1ps
module tb_dac_fault_config_powerdown;
    import dac_fault_pkg::*;
    logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, ovt = 0, en = 1;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, echo;
    logic        sdo, sdo_oe_n;
    logic [4:0]  open_in = 5'h00, pov_in = 5'h00, hiz, neg;
    logic        sck, sdi, sel_n, pready, perr, err_s, alarm_oe_n, ref_pd, ext_ref;
    logic [79:0] code;
    logic [19:0] span;
    logic [15:0] val;
    int          errors = 0, num_checks = 0, seed = 89;
    spi_host_model host (.core_clk_in(clk), .sdo_in(sdo), .sck_out(sck), .sdi_out(sdi),
                         .select_load_n_out(sel_n), .echo_out(echo));
    dac_fault_config_powerdown dut (.core_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(en),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
        .select_load_n_in(sel_n), .sck_in(sck), .sdi_in(sdi), .sdo_out(sdo),
        .sdo_oe_n_out(sdo_oe_n),
        .open_detect_in(open_in), .power_over_in(pov_in), .overtemp_in(ovt),
        .temp_recovered_in(~ovt), .alarm_pin_in(alarm_oe_n), .alarm_pin_out(),
        .alarm_oe_n_out(alarm_oe_n), .dac_code_out(code), .span_out(span),
        .output_hiz_out(hiz), .neg_switch_out(neg), .ref_powered_down_out(ref_pd),
        .ext_ref_select_out(ext_ref));
    // 40 MHz core clock
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        @(posedge clk);
        while (pready !== 1'b1 && k < 20)
        begin
            @(posedge clk);
            k++;
        end
        if (pready !== 1'b1)
        begin
            errors++;
            final_report();
        end
        else
        begin
            rd = prdata;
            err_s = perr;
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask : apb
    // Host waits out the wake-up settling time
    task automatic wait_wake();
        int n;
        n = 0;
        apb(1'b0, REG_POWER, 32'h0);
        chk("wake busy", 1, rd[PW_WAKE]);
        while (rd[PW_WAKE] !== 1'b0 && n < 200)
        begin
            repeat (8) @(posedge clk);
            apb(1'b0, REG_POWER, 32'h0);
            n++;
        end
        if (rd[PW_WAKE] !== 1'b0)
        begin
            errors++;
            final_report();
        end
    endtask : wait_wake
    task automatic spi(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
        host.send({8'h00, c, a, d}, 32);
    endtask : spi
    task automatic status();
        repeat (8) @(posedge clk);
        apb(1'b0, REG_STATUS, 32'h0);
    endtask : status
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, REG_CONFIG, 32'h0);
        chk("config", 32'h0, rd);
        spi(CMD_CONFIG, 4'h0, 16'h0001);
        chk("ext ref", 1, ext_ref);
        spi(CMD_CONFIG, 4'h0, 16'h0000);
        chk("int ref", 0, ext_ref);
        chk("echo", 32'h0070_0001, echo);
        chk("sdo released", 1, sdo_oe_n);
        en <= 1'b0;
        spi(CMD_CONFIG, 4'h0, 16'h0001);
        chk("frozen", 0, ext_ref);
        en <= 1'b1;
        $display("reference test done");
        val = 16'($random(seed));
        spi(CMD_SPAN_N, 4'h2, {12'h000, SPAN_100MA});
        spi(CMD_WR_N_UPD_N, 4'h2, val);
        chk("hiz on", 0, hiz[2]);
        spi(CMD_PD_N, 4'h2, 16'($random(seed)));
        chk("hiz pd", 1, hiz[2]);
        chk("code kept", val, code[47:32]);
        spi(CMD_UPD_N, 4'h2, 16'h0000);
        chk("hiz wake", 0, hiz[2]);
        wait_wake();
        spi(CMD_PD_CHIP, 4'h0, 16'($random(seed)));
        chk("ref pd", 1, ref_pd);
        chk("hiz chip", 5'h1F, hiz);
        $display("power-down test done");
        spi(CMD_SPAN_ALL, 4'h0, {12'h000, SPAN_NEG});
        chk("neg all", 5'h1F, neg);
        spi(CMD_SPAN_N, 4'h2, {12'h000, SPAN_HIZ});
        chk("neg ch2 off", 5'h1B, neg);
        spi(CMD_SPAN_N, 4'h1, {12'h000, SPAN_200MA});
        spi(CMD_UPD_ALL, 4'h0, 16'h0000);
        chk("hiz ch1", 0, hiz[1]);
        wait_wake();
        pov_in <= 5'h02;
        status();
        chk("power flag", 1, rd[FLAG_PWR]);
        chk("span fold", SPAN_100MA, span[7:4]);
        pov_in <= 5'h00;
        spi(CMD_CONFIG, 4'h0, 16'h0008);
        open_in <= 5'h11;
        status();
        chk("open masked", 5'h00, rd[4:0]);
        host.send({8'h00, CMD_CONFIG, 4'h0, 16'h0000}, 24);
        status();
        chk("open flags", 5'h11, rd[4:0]);
        open_in <= 5'h00;
        $display("span and flag test done");
        host.send({8'h00, CMD_CONFIG, 4'h0, 16'h0001}, 25);
        status();
        chk("length flag", 1, rd[FLAG_LEN]);
        chk("alarm set", 0, alarm_oe_n);
        chk("discarded", 0, ext_ref);
        spi(CMD_UPD_ALL, 4'h0, 16'h0000);
        chk("alarm free", 1, alarm_oe_n);
        chk("echo len", 32'h8070_0001, echo);
        ovt <= 1'b1;
        status();
        chk("hot flag", 1, rd[FLAG_OVT]);
        chk("hot hiz", 5'h1F, hiz);
        chk("hot alarm", 0, alarm_oe_n);
        chk("shutdown bit", 1, rd[ST_SHUTDOWN]);
        chk("pin level", 0, rd[ST_PIN]);
        spi(CMD_UPD_ALL, 4'h0, 16'h0000);
        chk("alarm hot free", 1, alarm_oe_n);
        chk("still shut", 5'h1F, hiz);
        chk("echo hot", 32'h2090_0000, echo);
        $display("alarm test done");
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        chk("slverr", 1, err_s);
        final_report();
    end
endmodule : tb_dac_fault_config_powerdown
